//--- bench/boost_sup_sva.sv
// Purpose: port-level checks for the boost supervisor
// Assumes: enable_i held high, so rst_i alone resets the block
// Notes:   input delays cover the two-flop synchronisers
`timescale 1ns/1ps
module boost_sup_sva #(
    parameter int UV_CYC       = 50,
    parameter int RECOVERY_LEN = 20
) (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic       channels_active_i,
    input wire logic       overvoltage_low_level_i,
    input wire logic       overvoltage_high_level_i,
    input wire logic       boost_undervoltage_level_i,
    input wire logic       boost_sync_input_i,
    input wire logic       boost_int_clk_i,
    input wire logic       reg_wr_i,
    input wire logic [1:0] spread_deviation_wdata_i,
    input wire logic [1:0] spread_rate_wdata_i,
    input wire logic [2:0] flag_clear_i,
    input wire logic [1:0] spread_deviation_select_o,
    input wire logic [1:0] spread_rate_select_o,
    input wire logic [7:0] boost_setpoint_o,
    input wire logic       switching_enable_o,
    input wire logic       fault_recovery_o,
    input wire logic       boost_overvolt_low_flag_o,
    input wire logic       boost_overvolt_high_flag_o,
    input wire logic       boost_overcurrent_flag_o,
    input wire logic       ext_sync_active_o,
    input wire logic       spread_enable_o,
    input wire logic [7:0] spread_offset_o,
    input wire logic       boost_clk_o
);
    // ======
    // run-length counters
    int uv_cnt_ff, nxt_uv_cnt, rec_cnt_ff, nxt_rec_cnt;
    always_comb begin
        nxt_uv_cnt  = (rst_i || !boost_undervoltage_level_i) ? 0 : uv_cnt_ff + 1;
        nxt_rec_cnt = (rst_i || !fault_recovery_o) ? 0 : rec_cnt_ff + 1;
    end
    always_ff @(posedge mclk_i) begin
        uv_cnt_ff  <= nxt_uv_cnt;
        rec_cnt_ff <= nxt_rec_cnt;
    end
    // ======
    // properties
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    chk_ovl_stop: assert property (
        overvoltage_low_level_i[*4] |-> !switching_enable_o && boost_overvolt_low_flag_o)
        else $error("ovl not gating");
    chk_ovh_enter: assert property (
        overvoltage_high_level_i[*4] |-> fault_recovery_o && boost_overvolt_high_flag_o)
        else $error("ovh no recovery");
    chk_ovh_sticky: assert property (
        boost_overvolt_high_flag_o && !flag_clear_i[1] |=> boost_overvolt_high_flag_o)
        else $error("ovh flag lost");
    chk_idle_init: assert property (
        !channels_active_i[*4] |-> boost_setpoint_o == 8'hE0)
        else $error("init setpoint");
    chk_step_size: assert property (
        (channels_active_i && !fault_recovery_o)[*4] ##0 $changed(boost_setpoint_o)
        |-> 8'(boost_setpoint_o - $past(boost_setpoint_o)) inside {8'h01, 8'hFF})
        else $error("step too large");
    chk_uv_early: assert property (
        $rose(boost_overcurrent_flag_o) |-> uv_cnt_ff >= UV_CYC)
        else $error("ocp flag early");
    chk_uv_expiry: assert property (
        uv_cnt_ff == UV_CYC + 8 |-> boost_overcurrent_flag_o)
        else $error("ocp flag late");
    chk_rec_length: assert property (
        rec_cnt_ff <= RECOVERY_LEN + 2)
        else $error("recovery long");
    chk_rec_min: assert property (
        $rose(fault_recovery_o) |-> fault_recovery_o[*8] ##0 !switching_enable_o)
        else $error("recovery short");
    chk_sync_nospread: assert property (
        ext_sync_active_o[*2] |-> !spread_enable_o)
        else $error("spread with ext");
    chk_ext_clock: assert property (
        ext_sync_active_o[*5] |-> boost_clk_o == $past(boost_sync_input_i, 3))
        else $error("ext clock path");
    chk_int_clock: assert property (
        !ext_sync_active_o[*5] |-> boost_clk_o == $past(boost_int_clk_i, 3))
        else $error("int clock path");
    chk_spread_off: assert property (
        !spread_enable_o[*3] |-> spread_offset_o == 8'h00)
        else $error("offset while off");
    chk_reg_write: assert property (
        reg_wr_i |=> spread_deviation_select_o == $past(spread_deviation_wdata_i)
        && spread_rate_select_o == $past(spread_rate_wdata_i))
        else $error("write lost");
endmodule : boost_sup_sva
bind boost_supervisor boost_sup_sva #(.UV_CYC(UV_CYC), .RECOVERY_LEN(RECOVERY_LEN)) sva_i (.*);

//--- bench/boost_supervisor_tb_top.sv
// Purpose: self-checking bench for the boost supervisor
// Assumes: short fault timers through parameters
// Notes:   expected setpoints from nsp
`timescale 1ns/1ps
module boost_supervisor_tb_top;
    localparam int UVC = 50;
    localparam int RCL = 20;
    logic        mclk_i = 0, rst_i = 1, enable_i = 1, reg_wr_i = 0, run = 0, lvl = 1;
    logic        channels_active_i = 0, overvoltage_low_level_i = 0;
    logic        overvoltage_high_level_i = 0, boost_undervoltage_level_i = 0;
    logic [2:0]  string_config_pin_i = 0, flag_clear_i = 0;
    logic [3:0]  sink_headroom_low_i = 0, sink_headroom_touch_i = 0;
    logic [3:0]  sink_open_fault_i = 0, sink_short_fault_i = 0;
    logic [1:0]  spread_deviation_wdata_i = 0, spread_rate_wdata_i = 0;
    logic [1:0]  spread_deviation_select_o, spread_rate_select_o;
    logic [7:0]  boost_setpoint_o, spread_offset_o;
    logic        boost_sync_input_i, boost_int_clk_i, switching_enable_o, fault_recovery_o;
    logic        boost_overvolt_low_flag_o, boost_overvolt_high_flag_o, boost_overcurrent_flag_o;
    logic        ext_sync_active_o, spread_enable_o, boost_clk_o;
    int          n_fail = 0, checks_done = 0, cyc = 0;
    logic [31:0] seed = 32'h53;
    boost_supervisor #(.UV_CYC(UVC), .RECOVERY_LEN(RCL)) uut (.*);
    sync_partner peer (.run_i(run), .level_i(lvl), .sync_o(boost_sync_input_i),
                       .int_clk_o(boost_int_clk_i));
    always #5 mclk_i = ~mclk_i;
    // ======
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [7:0] nsp(logic [2:0] c, logic [3:0] lo, logic [3:0] to,
                                       logic [3:0] fl, logic [7:0] s);
        logic [3:0] m;
        m = (c == 3'h1 ? 4'h7 : c == 3'h2 ? 4'h3 : 4'hF) & ~fl;
        if (m == 4'h0) return s;
        if (|(lo & m)) return (s == 8'hFF) ? s : s + 8'h01;
        if (!(|(to & m))) return (s == 8'h00) ? s : s - 8'h01;
        return s;
    endfunction : nsp
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tk
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic summarize();
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : summarize
    task automatic clr();
        flag_clear_i <= 3'h7;
        tk(1);
        flag_clear_i <= 3'h0;
        tk(2);
    endtask : clr
    task automatic sp_case(logic [2:0] c, logic [3:0] lo, logic [3:0] to, logic [3:0] op,
                           logic [3:0] sh);
        logic [7:0] s0;
        string_config_pin_i <= c;
        sink_headroom_low_i <= lo;
        sink_headroom_touch_i <= to;
        sink_open_fault_i <= op;
        sink_short_fault_i <= sh;
        tk(6);
        s0 = boost_setpoint_o;
        for (int i = 0; i < 1010 && boost_setpoint_o === s0; i++) tk(1);
        chk("setpoint", boost_setpoint_o, nsp(c, lo, to, op | sh, s0));
    endtask : sp_case
    task automatic sy(logic rn, logic lv, logic ex, logic sp);
        run <= rn;
        lvl <= lv;
        tk(4100);
        chk("ext sync", ext_sync_active_o, ex);
        chk("spread", spread_enable_o, sp);
    endtask : sy
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            summarize();
        end
    end
    // ======
    // main sequence
    initial begin
        logic [31:0] r;
        tk(8);
        rst_i <= 0;
        tk(2);
        chk("dev reset", 8'(spread_deviation_select_o), 8'h02);
        chk("rate reset", 8'(spread_rate_select_o), 8'h00);
        tk(1500);
        chk("idle setpoint", boost_setpoint_o, 8'hE0);
        for (int i = 0; i < 4; i++) begin
            reg_wr_i <= 1;
            spread_deviation_wdata_i <= 2'(i);
            spread_rate_wdata_i <= 2'(3 - i);
            tk(1);
            reg_wr_i <= 0;
            tk(1);
            chk("dev", 8'(spread_deviation_select_o), 8'(i));
            chk("rate", 8'(spread_rate_select_o), 8'(3 - i));
        end
        channels_active_i <= 1;
        sp_case(3'h2, 4'hC, 4'h0, 4'h0, 4'h0);
        sp_case(3'h0, 4'h1, 4'h0, 4'h1, 4'h0);
        sp_case(3'h0, 4'h2, 4'h0, 4'h0, 4'h2);
        sp_case(3'h0, 4'h2, 4'h0, 4'h0, 4'h0);
        sp_case(3'h1, 4'h0, 4'h4, 4'h0, 4'h0);
        repeat (8) begin
            r = xs();
            sp_case(3'(r % 5), r[7:4], r[11:8], r[15:12] & r[19:16], r[23:20] & r[27:24]);
        end
        overvoltage_low_level_i <= 1;
        tk(5);
        chk("ovl switching", switching_enable_o, 8'h00);
        chk("ovl flag", boost_overvolt_low_flag_o, 8'h01);
        overvoltage_low_level_i <= 0;
        tk(5);
        chk("ovl resume", switching_enable_o, 8'h01);
        clr();
        chk("ovl clear", boost_overvolt_low_flag_o, 8'h00);
        overvoltage_high_level_i <= 1;
        tk(7);
        overvoltage_high_level_i <= 0;
        chk("ovh recovery", fault_recovery_o, 8'h01);
        chk("ovh flag", boost_overvolt_high_flag_o, 8'h01);
        chk("ovh setpoint", boost_setpoint_o, 8'hE0);
        tk(RCL + 10);
        chk("recovery end", fault_recovery_o, 8'h00);
        clr();
        boost_undervoltage_level_i <= 1;
        tk(UVC - 10);
        boost_undervoltage_level_i <= 0;
        tk(UVC + 10);
        chk("uv early", boost_overcurrent_flag_o, 8'h00);
        boost_undervoltage_level_i <= 1;
        tk(UVC + 10);
        chk("uv recovery", fault_recovery_o, 8'h01);
        chk("uv flag", boost_overcurrent_flag_o, 8'h01);
        boost_undervoltage_level_i <= 0;
        tk(RCL + 10);
        clr();
        sy(1'b0, 1'b1, 1'b0, 1'b1);
        sy(1'b1, 1'b1, 1'b1, 1'b0);
        sy(1'b0, 1'b0, 1'b0, 1'b0);
        sy(1'b1, 1'b0, 1'b1, 1'b0);
        sy(1'b0, 1'b1, 1'b0, 1'b1);
        summarize();
    end
endmodule : boost_supervisor_tb_top

//--- bench/sync_partner.sv
// Purpose: far side: sync pin source and internal oscillator
// Assumes: 1 MHz external clock, 400 kHz internal clock
// Notes:   a stopped sync clock settles to the requested static level
`timescale 1ns/1ps
module sync_partner #(
    parameter int EXT_HALF_NS = 500,
    parameter int INT_HALF_NS = 1250
) (
    input  wire logic run_i,
    input  wire logic level_i,
    output logic      sync_o,
    output logic      int_clk_o
);
    initial begin
        sync_o = 1'b0;
        int_clk_o = 1'b0;
    end
    always #(INT_HALF_NS) int_clk_o = ~int_clk_o;
    // clock in range, else static level
    always #(EXT_HALF_NS) sync_o = run_i ? ~sync_o : level_i;
endmodule : sync_partner

//--- design/boost_clk_if.sv
// Purpose: clock-mode signals between supervisor and helpers
// Assumes: single clock domain
// Notes:   sync_level is already synchronised

`timescale 1ns/1ps

interface boost_clk_if;
    logic       sync_level;
    logic       ext_present;
    logic       static_level;
    logic       spread_en;
    logic [1:0] dev_sel;
    logic [1:0] rate_sel;
    logic [7:0] spread_offset;

    modport detect (input sync_level, output ext_present, output static_level);
    modport spread (input spread_en, input dev_sel, input rate_sel, output spread_offset);
    modport ctrl   (output sync_level, input ext_present, input static_level,
                    output spread_en, output dev_sel, output rate_sel, input spread_offset);
endinterface : boost_clk_if

//--- design/boost_sup_pkg.sv
// Purpose: shared constants and helpers for the boost supervisor
// Assumes: 100 MHz system clock
// Notes:   setpoint is an abstract 8-bit code, min to max

package boost_sup_pkg;

    // ======
    // clock and timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int CHECK_US      = 10;
    localparam int CHECK_CYC     = CHECK_US * (CLK_HZ / 1_000_000);
    localparam int UV_TIMEOUT_MS = 110;
    localparam int UV_TIMEOUT_CYC = UV_TIMEOUT_MS * (CLK_HZ / 1_000);
    localparam int RECOVERY_MS   = 1;
    localparam int RECOVERY_CYC  = RECOVERY_MS * (CLK_HZ / 1_000);
    localparam int SYNC_WIN_US   = 20;
    localparam int SYNC_WIN_CYC  = SYNC_WIN_US * (CLK_HZ / 1_000_000);

    // ======
    // setpoint
    localparam int            SP_W          = 8;
    localparam logic [SP_W-1:0] SP_MIN      = 8'h00;
    localparam logic [SP_W-1:0] SP_MAX      = 8'hFF;
    localparam int            INIT_PERMILLE = 880;
    localparam logic [SP_W-1:0] SP_INIT     = SP_W'((255 * INIT_PERMILLE) / 1000);

    // ======
    // sync detection
    localparam logic [2:0] SYNC_MIN_EDGES = 3'h2;
    localparam logic [2:0] SYNC_NO_EDGES  = 3'h0;
    localparam logic [2:0] SYNC_EDGE_SAT  = 3'h7;

    // ======
    // register reset values
    localparam logic [1:0] DEV_RESET  = 2'h2;
    localparam logic [1:0] RATE_RESET = 2'h0;

    // ======
    // string configuration codes
    localparam logic [2:0] CFG_FOUR     = 3'h0;
    localparam logic [2:0] CFG_THREE    = 3'h1;
    localparam logic [2:0] CFG_TWO      = 3'h2;
    localparam logic [2:0] CFG_TWO_PAIR = 3'h3;
    localparam logic [2:0] CFG_ONE      = 3'h4;
    localparam int         NUM_SINKS    = 4;

    // ======
    // fault states
    typedef enum logic [2:0] {
        ST_RUN      = 3'b001,
        ST_UV_TIME  = 3'b010,
        ST_RECOVERY = 3'b100
    } fault_state_t;

    // sinks wired for a configuration
    function automatic logic [NUM_SINKS-1:0] active_mask(input logic [2:0] cfg);
        case (cfg)
            CFG_FOUR:     active_mask = 4'hF;
            CFG_THREE:    active_mask = 4'h7;
            CFG_TWO:      active_mask = 4'h3;
            CFG_TWO_PAIR: active_mask = 4'hF;
            CFG_ONE:      active_mask = 4'hF;
            default:      active_mask = 4'hF;
        endcase
    endfunction : active_mask

    // swing amplitude in 0.1 % units
    function automatic logic [7:0] dev_amp(input logic [1:0] sel);
        case (sel)
            2'h0:    dev_amp = 8'h21;
            2'h1:    dev_amp = 8'h2B;
            2'h2:    dev_amp = 8'h35;
            default: dev_amp = 8'h48;
        endcase
    endfunction : dev_amp

    // modulation rate in Hz
    function automatic int rate_hz(input logic [1:0] sel);
        case (sel)
            2'h0:    rate_hz = 200;
            2'h1:    rate_hz = 500;
            2'h2:    rate_hz = 800;
            default: rate_hz = 1200;
        endcase
    endfunction : rate_hz

    // cycles per 0.1 % step of the triangle
    function automatic logic [15:0] step_cycles(input logic [1:0] dev, input logic [1:0] rate);
        int steps;
        steps = 4 * int'(dev_amp(dev)) * rate_hz(rate);
        step_cycles = 16'(CLK_HZ / steps);
    endfunction : step_cycles

endpackage : boost_sup_pkg

//--- design/boost_supervisor.sv
// Purpose: adaptive setpoint, boost fault supervision, clock selection
// Assumes: comparator and sink inputs are async levels
// Notes:   enable low holds the block in reset, all but the input synchronisers

`timescale 1ns/1ps

// Behaviour
// - only configured sinks steer the setpoint
// - open or short faulted sinks never steer the setpoint
// - per check, up if a sink is low, else down until one touches
// - setpoint held near 88 percent until channels active
// - overvoltage-low gates switching, sets flag; resumes once clear
// - overvoltage-high enters fault recovery and sets its flag
// - undervoltage for 110 ms enters recovery, sets overcurrent flag
// - static sync high enables spread, low disables it
// - external sync clock drives switching, spread forced off
// - lost sync falls back to internal clock; final level sets spread
// - deviation field selects swing 3.3/4.3/5.3/7.2 percent, resets to 10
// - rate field selects 200/500/800/1200 Hz, resets to 00
// - sync clock presence detected from start-up
module boost_supervisor
    import boost_sup_pkg::*;
#(
    parameter int UV_CYC       = UV_TIMEOUT_CYC,
    parameter int RECOVERY_LEN = RECOVERY_CYC
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_i,
    input  wire logic           enable_i,
    input  wire logic           boost_sync_input_i,
    input  wire logic           boost_int_clk_i,
    input  wire logic [2:0]     string_config_pin_i,
    input  wire logic [3:0]     sink_headroom_low_i,
    input  wire logic [3:0]     sink_headroom_touch_i,
    input  wire logic [3:0]     sink_open_fault_i,
    input  wire logic [3:0]     sink_short_fault_i,
    input  wire logic           channels_active_i,
    input  wire logic           overvoltage_low_level_i,
    input  wire logic           overvoltage_high_level_i,
    input  wire logic           boost_undervoltage_level_i,
    input  wire logic           reg_wr_i,
    input  wire logic [1:0]     spread_deviation_wdata_i,
    input  wire logic [1:0]     spread_rate_wdata_i,
    input  wire logic [2:0]     flag_clear_i,
    output logic [1:0]          spread_deviation_select_o,
    output logic [1:0]          spread_rate_select_o,
    output logic [SP_W-1:0]     boost_setpoint_o,
    output logic                switching_enable_o,
    output logic                fault_recovery_o,
    output logic                boost_overvolt_low_flag_o,
    output logic                boost_overvolt_high_flag_o,
    output logic                boost_overcurrent_flag_o,
    output logic                ext_sync_active_o,
    output logic                spread_enable_o,
    output logic [7:0]          spread_offset_o,
    output logic                boost_clk_o
);

    // ======
    // input synchronisers
    localparam int IN_W = 26;

    logic [IN_W-1:0] meta_ff;
    logic [IN_W-1:0] sync_ff;
    logic [IN_W-1:0] raw_in;

    assign raw_in = {sink_headroom_low_i, sink_headroom_touch_i, sink_open_fault_i,
                     sink_short_fault_i, string_config_pin_i, channels_active_i,
                     overvoltage_low_level_i, overvoltage_high_level_i,
                     boost_undervoltage_level_i, boost_sync_input_i, boost_int_clk_i,
                     enable_i};

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= raw_in;
            sync_ff <= meta_ff;
        end
    end

    logic [3:0] low_q;
    logic [3:0] touch_q;
    logic [3:0] open_q;
    logic [3:0] short_q;
    logic [2:0] cfg_q;
    logic       active_q;
    logic       ovl_q;
    logic       ovh_q;
    logic       uv_q;
    logic       sync_q;
    logic       intclk_q;
    logic       en_q;
    logic       blk_rst;

    assign {low_q, touch_q, open_q, short_q, cfg_q, active_q, ovl_q, ovh_q,
            uv_q, sync_q, intclk_q, en_q} = sync_ff;
    assign blk_rst = rst_i | ~en_q;

    // ======
    // spread configuration registers
    logic [1:0] dev_ff,  nxt_dev;
    logic [1:0] rate_ff, nxt_rate;

    always_comb begin
        nxt_dev  = reg_wr_i ? spread_deviation_wdata_i : dev_ff;
        nxt_rate = reg_wr_i ? spread_rate_wdata_i : rate_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            dev_ff  <= DEV_RESET;
            rate_ff <= RATE_RESET;
        end else begin
            dev_ff  <= nxt_dev;
            rate_ff <= nxt_rate;
        end
    end

    // ======
    // clock mode helpers
    boost_clk_if clk_bus ();

    assign clk_bus.sync_level = sync_q;
    assign clk_bus.dev_sel    = dev_ff;
    assign clk_bus.rate_sel   = rate_ff;
    assign clk_bus.spread_en  = ~clk_bus.ext_present & clk_bus.static_level;

    sync_detect u_sync_detect (
        .mclk_i    (mclk_i),
        .blk_rst_i (blk_rst),
        .bus       (clk_bus.detect)
    );

    spread_mod u_spread_mod (
        .mclk_i    (mclk_i),
        .blk_rst_i (blk_rst),
        .bus       (clk_bus.spread)
    );

    // ======
    // fault supervision
    fault_state_t state_ff, nxt_state;
    logic [31:0]  cnt_ff,   nxt_cnt;
    logic [2:0]   flag_ff,  nxt_flag;
    logic         sw_en_ff, nxt_sw_en;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_flag  = flag_ff & ~flag_clear_i;
        case (state_ff)
            ST_RUN: begin
                nxt_cnt = 32'h0000_0000;
                if (ovh_q) begin
                    nxt_state = ST_RECOVERY;
                end else if (uv_q) begin
                    nxt_state = ST_UV_TIME;
                end
            end
            ST_UV_TIME: begin
                if (ovh_q) begin
                    nxt_state = ST_RECOVERY;
                    nxt_cnt   = 32'h0000_0000;
                end else if (!uv_q) begin
                    nxt_state = ST_RUN;
                    nxt_cnt   = 32'h0000_0000;
                end else if (cnt_ff >= 32'(UV_CYC - 1)) begin
                    nxt_state = ST_RECOVERY;
                    nxt_cnt   = 32'h0000_0000;
                    nxt_flag[2] = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + 32'h0000_0001;
                end
            end
            ST_RECOVERY: begin
                if (cnt_ff >= 32'(RECOVERY_LEN - 1)) begin
                    nxt_state = ST_RUN;
                    nxt_cnt   = 32'h0000_0000;
                end else begin
                    nxt_cnt = cnt_ff + 32'h0000_0001;
                end
            end
            default: begin
                nxt_state = ST_RUN;
                nxt_cnt   = 32'h0000_0000;
            end
        endcase
        // hardware set wins over a same-cycle clear
        if (ovl_q) begin
            nxt_flag[0] = 1'b1;
        end
        if (ovh_q) begin
            nxt_flag[1] = 1'b1;
        end
        nxt_sw_en = (nxt_state != ST_RECOVERY) & ~ovl_q;
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            state_ff <= ST_RUN;
            cnt_ff   <= 32'h0000_0000;
            flag_ff  <= 3'h0;
            sw_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            flag_ff  <= nxt_flag;
            sw_en_ff <= nxt_sw_en;
        end
    end

    // ======
    // adaptive setpoint
    logic [SP_W-1:0] sp_ff,    nxt_sp;
    logic [15:0]     chk_ff,   nxt_chk;
    logic [3:0]      monitored;
    logic            chk_tick;

    always_comb begin
        monitored = active_mask(cfg_q) & ~(open_q | short_q);
        chk_tick  = (chk_ff == 16'(CHECK_CYC - 1));
        nxt_chk   = chk_tick ? 16'h0000 : chk_ff + 16'h0001;
        nxt_sp    = sp_ff;
        if (!active_q || state_ff == ST_RECOVERY) begin
            nxt_sp = SP_INIT;
        end else if (chk_tick && monitored != 4'h0) begin
            if ((low_q & monitored) != 4'h0) begin
                if (sp_ff != SP_MAX) begin
                    nxt_sp = sp_ff + 8'h01;
                end
            end else if ((touch_q & monitored) == 4'h0 && sp_ff != SP_MIN) begin
                nxt_sp = sp_ff - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            sp_ff  <= SP_INIT;
            chk_ff <= 16'h0000;
        end else begin
            sp_ff  <= nxt_sp;
            chk_ff <= nxt_chk;
        end
    end

    // ======
    // boost clock output
    logic clk_ff, nxt_clk;
    logic ss_ff,  nxt_ss;
    logic [7:0] ofs_ff, nxt_ofs;

    always_comb begin
        nxt_clk = clk_bus.ext_present ? sync_q : intclk_q;
        nxt_ss  = clk_bus.spread_en;
        nxt_ofs = clk_bus.spread_offset;
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst) begin
            clk_ff <= 1'b0;
            ss_ff  <= 1'b0;
            ofs_ff <= 8'h00;
        end else begin
            clk_ff <= nxt_clk;
            ss_ff  <= nxt_ss;
            ofs_ff <= nxt_ofs;
        end
    end

    assign spread_deviation_select_o  = dev_ff;
    assign spread_rate_select_o       = rate_ff;
    assign boost_setpoint_o           = sp_ff;
    assign switching_enable_o         = sw_en_ff;
    assign fault_recovery_o           = (state_ff == ST_RECOVERY);
    assign boost_overvolt_low_flag_o  = flag_ff[0];
    assign boost_overvolt_high_flag_o = flag_ff[1];
    assign boost_overcurrent_flag_o   = flag_ff[2];
    assign ext_sync_active_o          = clk_bus.ext_present;
    assign spread_enable_o            = ss_ff;
    assign spread_offset_o            = ofs_ff;
    assign boost_clk_o                = clk_ff;

endmodule : boost_supervisor

//--- design/spread_mod.sv
// Purpose: triangle frequency offset for spread spectrum
// Assumes: signed offset, 0.1 % units
// Notes:   offset returns to zero while disabled

`timescale 1ns/1ps

module spread_mod
    import boost_sup_pkg::*;
(
    input  wire logic   mclk_i,
    input  wire logic   blk_rst_i,
    boost_clk_if.spread bus
);

    logic signed [7:0] pos_ff,  nxt_pos;
    logic              down_ff, nxt_down;
    logic [15:0]       tick_ff, nxt_tick;
    logic signed [7:0] amp;
    logic              step;

    always_comb begin
        amp      = signed'(dev_amp(bus.dev_sel));
        step     = (tick_ff >= step_cycles(bus.dev_sel, bus.rate_sel) - 16'h0001);
        nxt_tick = step ? 16'h0000 : tick_ff + 16'h0001;
        nxt_pos  = pos_ff;
        nxt_down = down_ff;
        if (!bus.spread_en) begin
            nxt_pos  = 8'sh00;
            nxt_down = 1'b0;
            nxt_tick = 16'h0000;
        end else if (step) begin
            if (!down_ff) begin
                if (pos_ff >= amp) begin
                    nxt_down = 1'b1;
                    nxt_pos  = pos_ff - 8'sh01;
                end else begin
                    nxt_pos  = pos_ff + 8'sh01;
                end
            end else begin
                if (pos_ff <= -amp) begin
                    nxt_down = 1'b0;
                    nxt_pos  = pos_ff + 8'sh01;
                end else begin
                    nxt_pos  = pos_ff - 8'sh01;
                end
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst_i) begin
            pos_ff  <= 8'sh00;
            down_ff <= 1'b0;
            tick_ff <= 16'h0000;
        end else begin
            pos_ff  <= nxt_pos;
            down_ff <= nxt_down;
            tick_ff <= nxt_tick;
        end
    end

    assign bus.spread_offset = pos_ff;

endmodule : spread_mod

//--- design/sync_detect.sv
// Purpose: external clock presence on the sync input
// Assumes: sync_level already passed two flip-flops
// Notes:   static level latched after an edgeless window

`timescale 1ns/1ps

module sync_detect
    import boost_sup_pkg::*;
(
    input  wire logic   mclk_i,
    input  wire logic   blk_rst_i,
    boost_clk_if.detect bus
);

    logic        prev_ff,    nxt_prev;
    logic [15:0] win_ff,     nxt_win;
    logic [2:0]  edges_ff,   nxt_edges;
    logic        present_ff, nxt_present;
    logic        level_ff,   nxt_level;
    logic        rise;
    logic        win_end;

    always_comb begin
        rise        = bus.sync_level & ~prev_ff;
        win_end     = (win_ff == 16'(SYNC_WIN_CYC - 1));
        nxt_prev    = bus.sync_level;
        nxt_win     = win_end ? 16'h0000 : win_ff + 16'h0001;
        nxt_edges   = edges_ff;
        nxt_present = present_ff;
        nxt_level   = level_ff;
        if (rise && edges_ff != SYNC_EDGE_SAT) begin
            nxt_edges = edges_ff + 3'h1;
        end
        if (win_end) begin
            nxt_edges = SYNC_NO_EDGES;
            if (edges_ff >= SYNC_MIN_EDGES) begin
                nxt_present = 1'b1;
            end else if (edges_ff == SYNC_NO_EDGES) begin
                nxt_present = 1'b0;
                nxt_level   = bus.sync_level;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (blk_rst_i) begin
            prev_ff    <= 1'b0;
            win_ff     <= 16'h0000;
            edges_ff   <= 3'h0;
            present_ff <= 1'b0;
            level_ff   <= 1'b0;
        end else begin
            prev_ff    <= nxt_prev;
            win_ff     <= nxt_win;
            edges_ff   <= nxt_edges;
            present_ff <= nxt_present;
            level_ff   <= nxt_level;
        end
    end

    assign bus.ext_present  = present_ff;
    assign bus.static_level = level_ff;

endmodule : sync_detect
